// [scp_pkg.sv]
// Constants and types shared by the serial configuration port
package scp_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned MEM_AW     = 8;
  localparam int unsigned MEM_DEPTH  = 256;
  localparam int unsigned RW_POS     = 7;
  localparam int unsigned LEN_HI_POS = 6;
  localparam int unsigned LEN_LO_POS = 5;
  localparam int unsigned AHI_TOP    = 4;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [2:0]  BIT_FIRST  = 3'h0;
  localparam logic [1:0]  LEN_STREAM = 2'h3;
  localparam logic [1:0]  LEFT_NONE  = 2'h0;
  localparam logic [12:0] ADDR_STEP  = 13'h0001;

  // ****************************************************************
  // Bit order control byte
  // ****************************************************************
  localparam logic [7:0]  CFG_ADDR    = 8'h00;
  localparam int unsigned CFG_LSB_POS = 6;

  typedef enum logic [1:0] {
    SCP_INSTR_HI,
    SCP_INSTR_LO,
    SCP_DATA
  } scp_phase_t;

endpackage : scp_pkg

// [scp_config_port.sv]
// Three-wire serial configuration port, device end
//
// How it works
// R01: Select fall then clock rise starts frame
// R02: Sixteen instruction bits, then sized data bytes
// R03: Shift only while select is low
// R04: Select may pause at byte boundaries
// R05: Length code 11 streams until deselect
// R06: Mid-byte deselect discards byte, restarts instruction
// R07: Select held high disables serial port
// R08: Select tied low gives two-wire mode
// R09: Host keeps two-wire transfers short
// R10: Two-wire streaming never ends
// R11: Instruction carries read or write direction
// R12: Read turns data pin to output
// R13: MSB first by default, LSB selectable
// R14: Direction, length bits, thirteen-bit address
// R15: Address steps after every data byte
`timescale 1ns/100ps
`default_nettype none

module scp_config_port (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        sclk_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        sdio_i,
  output var  logic        sdio_o,
  output var  logic        sdio_oe_n_o,
  output var  logic        cfg_wr_o,
  output var  logic [12:0] cfg_addr_o,
  output var  logic [7:0]  cfg_data_o,
  output var  logic        serial_off_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                          ce_s1;
    logic                          ce_s2;
    scp_pkg::scp_phase_t           phase;
    logic [2:0]                    cnt;
    logic [7:0]                    sh;
    logic                          rw;
    logic [1:0]                    len;
    logic [1:0]                    left;
    logic [12:0]                   addr;
    logic [7:0]                    tx;
    logic                          wr_tgl;
    logic [12:0]                   wr_addr;
    logic [7:0]                    wr_data;
    logic [255:0][7:0]             mem;
  } scp_link_t;

  typedef struct packed {
    logic                          tg1;
    logic                          tg2;
    logic                          tg3;
    logic                          cs1;
    logic                          cs2;
    logic                          wr;
    logic [12:0]                   addr;
    logic [7:0]                    data;
  } scp_ref_t;

  typedef struct packed {
    logic                          dat;
    logic                          oe_n;
  } scp_out_t;

  scp_link_t l_q, l_d;
  scp_ref_t  r_q, r_d;
  scp_out_t  o_q, o_d;
  logic      brk_q;

  function automatic logic [7:0] scp_shift(input logic [7:0] sh,
                                           input logic       d,
                                           input logic       lsb);
    scp_shift = lsb ? {d, sh[7:1]} : {sh[6:0], d};
  endfunction : scp_shift

  function automatic logic [7:0] scp_idx(input logic [12:0] a);
    scp_idx = a[scp_pkg::MEM_AW-1:0];
  endfunction : scp_idx

  // ****************************************************************
  // Link domain: deselect marker
  // ****************************************************************
  // Sclk may stand still while deselected, so a rising select is caught
  // asynchronously and judged at the next edge of the frame.
  always_ff @(posedge sclk_i or posedge chip_select_n_i or negedge rst_n_i)
  begin
    if (!rst_n_i) begin
      brk_q <= 1'b0;
    end else if (chip_select_n_i) begin
      brk_q <= 1'b1;
    end else begin
      brk_q <= brk_q & ~l_q.ce_s2;
    end
  end

  // ****************************************************************
  // Link domain: shifter and frame decode
  // ****************************************************************
  always_comb begin
    logic [2:0]          cnt_v;
    scp_pkg::scp_phase_t ph_v;
    logic [7:0]          byte_v;
    logic [12:0]         addr_v;
    logic                lsb_v;
    cnt_v  = l_q.cnt;
    ph_v   = l_q.phase;
    byte_v = l_q.sh;
    addr_v = l_q.addr;
    lsb_v  = l_q.mem[scp_pkg::CFG_ADDR][scp_pkg::CFG_LSB_POS];
    l_d       = l_q;
    l_d.ce_s1 = ce_i;
    l_d.ce_s2 = l_q.ce_s1;
    if (l_q.ce_s2 && !chip_select_n_i) begin // R03 R07
      if (brk_q) begin
        cnt_v = scp_pkg::BIT_FIRST; // R04
        if (l_q.cnt != scp_pkg::BIT_FIRST) begin
          ph_v = scp_pkg::SCP_INSTR_HI; // R06 R01
        end else if (l_q.phase == scp_pkg::SCP_DATA
                     && l_q.len == scp_pkg::LEN_STREAM) begin
          // Streaming has no byte count, so deselect is its only end
          ph_v = scp_pkg::SCP_INSTR_HI; // R05
        end
      end
      byte_v    = scp_shift(l_q.sh, sdio_i, lsb_v); // R13
      l_d.sh    = byte_v;
      l_d.cnt   = cnt_v + 3'h1;
      l_d.phase = ph_v;
      if (cnt_v == scp_pkg::BIT_LAST) begin
        case (ph_v)
          scp_pkg::SCP_INSTR_HI: begin // R02 R14 R11
            l_d.rw         = byte_v[scp_pkg::RW_POS];
            l_d.len        = byte_v[scp_pkg::LEN_HI_POS:scp_pkg::LEN_LO_POS];
            l_d.addr[12:8] = byte_v[scp_pkg::AHI_TOP:0];
            l_d.phase      = scp_pkg::SCP_INSTR_LO;
          end
          scp_pkg::SCP_INSTR_LO: begin // R02 R14
            addr_v    = {l_q.addr[12:8], byte_v};
            l_d.addr  = addr_v;
            l_d.left  = l_q.len;
            l_d.tx    = l_q.mem[scp_idx(addr_v)];
            l_d.phase = scp_pkg::SCP_DATA;
          end
          scp_pkg::SCP_DATA: begin
            if (!l_q.rw) begin
              l_d.mem[scp_idx(l_q.addr)] = byte_v;
              l_d.wr_tgl  = ~l_q.wr_tgl;
              l_d.wr_addr = l_q.addr;
              l_d.wr_data = byte_v;
            end
            addr_v   = l_q.addr + scp_pkg::ADDR_STEP; // R15
            l_d.addr = addr_v;
            l_d.tx   = l_d.mem[scp_idx(addr_v)];
            if (l_q.len == scp_pkg::LEN_STREAM) begin
              l_d.phase = scp_pkg::SCP_DATA; // R05 R10 R08
            end else if (l_q.left == scp_pkg::LEFT_NONE) begin
              l_d.phase = scp_pkg::SCP_INSTR_HI; // R09
            end else begin
              l_d.left = l_q.left - 2'h1;
            end
          end
          default: begin
            l_d.phase = scp_pkg::SCP_INSTR_HI;
          end
        endcase
      end
    end
  end

  // Reset puts two-wire mode in step with the host at power-up
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l_q <= '0; // R08
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************************************
  // Link domain: data pin driver on falling edge
  // ****************************************************************
  always_comb begin
    o_d = o_q;
    if (l_q.ce_s2) begin
      o_d.oe_n = 1'b1;
      if (l_q.phase == scp_pkg::SCP_DATA && l_q.rw) begin
        o_d.oe_n = 1'b0; // R12
        o_d.dat  = l_q.mem[scp_pkg::CFG_ADDR][scp_pkg::CFG_LSB_POS]
                   ? l_q.tx[l_q.cnt]
                   : l_q.tx[scp_pkg::BIT_LAST - l_q.cnt]; // R13
      end
    end
  end

  // Deselect releases the pin at once, even with the clock stopped
  always_ff @(negedge sclk_i or posedge chip_select_n_i or negedge rst_n_i)
  begin
    if (!rst_n_i) begin
      o_q <= '{dat: 1'b0, oe_n: 1'b1};
    end else if (chip_select_n_i) begin
      o_q <= '{dat: 1'b0, oe_n: 1'b1};
    end else begin
      o_q <= o_d;
    end
  end

  assign sdio_o      = o_q.dat;
  assign sdio_oe_n_o = o_q.oe_n;

  // ****************************************************************
  // Reference domain: write notice and port status
  // ****************************************************************
  // Write address and data are held for a whole byte time, far longer
  // than the toggle takes to cross, so they are sampled without sync.
  always_comb begin
    r_d = r_q;
    if (ce_i) begin
      r_d.tg1 = l_q.wr_tgl;
      r_d.tg2 = r_q.tg1;
      r_d.tg3 = r_q.tg2;
      r_d.cs1 = chip_select_n_i;
      r_d.cs2 = r_q.cs1; // R07
      r_d.wr  = r_q.tg2 ^ r_q.tg3;
      if (r_q.tg2 ^ r_q.tg3) begin
        r_d.addr = l_q.wr_addr;
        r_d.data = l_q.wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign cfg_wr_o     = r_q.wr;
  assign cfg_addr_o   = r_q.addr;
  assign cfg_data_o   = r_q.data;
  assign serial_off_o = r_q.cs2;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_INSTR_HI_DONE: assert property ( // R02
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && !brk_q && l_q.cnt == 3'h7
     && l_q.phase == scp_pkg::SCP_INSTR_HI)
    |=> (l_q.phase == scp_pkg::SCP_INSTR_LO && l_q.cnt == 3'h0))
    else $error("instruction high byte not taken");

  AST_INSTR_LO_DONE: assert property ( // R14
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && !brk_q && l_q.cnt == 3'h7
     && l_q.phase == scp_pkg::SCP_INSTR_LO)
    |=> (l_q.phase == scp_pkg::SCP_DATA && l_q.left == $past(l_q.len)))
    else $error("data phase not entered after instruction");

  AST_STREAM_HOLD: assert property ( // R05
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && l_q.cnt == 3'h7 && !brk_q
     && l_q.phase == scp_pkg::SCP_DATA && l_q.len == 2'h3)
    |=> l_q.phase == scp_pkg::SCP_DATA)
    else $error("streaming left without deselect");

  AST_ADDR_STEP: assert property ( // R15
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && l_q.cnt == 3'h7 && !brk_q
     && l_q.phase == scp_pkg::SCP_DATA)
    |=> l_q.addr == $past(l_q.addr) + 13'h0001)
    else $error("address did not step after data byte");

  AST_ABORT_MID: assert property ( // R06
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && brk_q && l_q.cnt != 3'h0)
    |=> (l_q.phase == scp_pkg::SCP_INSTR_HI && l_q.cnt == 3'h1))
    else $error("partial byte not discarded on deselect");

  AST_RESUME: assert property ( // R04
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && brk_q && l_q.cnt == 3'h0
     && !(l_q.phase == scp_pkg::SCP_DATA && l_q.len == 2'h3))
    |=> (l_q.phase == $past(l_q.phase) && l_q.cnt == 3'h1))
    else $error("transfer lost across a byte-boundary pause");

  AST_STREAM_END: assert property ( // R05
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && brk_q && l_q.cnt == 3'h0
     && l_q.phase == scp_pkg::SCP_DATA && l_q.len == 2'h3)
    |=> (l_q.phase == scp_pkg::SCP_INSTR_HI && l_q.cnt == 3'h1))
    else $error("streaming kept on after deselect");

  AST_IGNORE_DESEL: assert property ( // R03
    @(posedge sclk_i) disable iff (!rst_n_i)
    chip_select_n_i |=> $stable(l_q.cnt) && $stable(l_q.phase))
    else $error("shifted while deselected");

  AST_DRIVE_READ: assert property ( // R12
    @(posedge sclk_i) disable iff (!rst_n_i)
    (!chip_select_n_i && l_q.ce_s2 && $past(l_q.ce_s2) && !brk_q
     && l_q.phase == scp_pkg::SCP_DATA && l_q.rw) |-> !sdio_oe_n_o)
    else $error("data pin not driven during read");

  AST_QUIET_INSTR: assert property ( // R12
    @(posedge sclk_i) disable iff (!rst_n_i)
    (l_q.phase == scp_pkg::SCP_INSTR_HI) |-> sdio_oe_n_o)
    else $error("data pin driven during instruction");

  AST_WRITE_NOTICE: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ce_i && (r_q.tg2 != r_q.tg3)) |=> (cfg_wr_o ##1 !cfg_wr_o || !ce_i))
    else $error("write notice not a single pulse");

endmodule : scp_config_port

`default_nettype wire

// [scp_host_model.sv]
// Behavioural host that drives the serial configuration link
`timescale 1ns/100ps
`default_nettype none

module scp_host_model (
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic sdio_o,
  output var  logic sdio_en_o,
  input  wire logic sdio_i
);
  localparam time HALF = 24ns;

  initial begin
    sclk_o    = 1'b0;
    cs_n_o    = 1'b1;
    sdio_o    = 1'b0;
    sdio_en_o = 1'b0;
  end

  // Clock rests low between pulses, in or out of a frame
  task automatic pulses(input int n);
    repeat (n) begin
      #HALF sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
    end
  endtask : pulses

  // Select moves only with the clock low, away from any edge
  task automatic select(input logic lvl);
    #HALF cs_n_o = lvl;
    if (lvl) sdio_en_o = 1'b0;
    #HALF;
  endtask : select

  // One whole byte; a read byte leaves the line to the device
  task automatic shift(input logic [7:0] tx, input logic rd,
                       input logic lsb, output logic [7:0] rx);
    int k;
    for (int i = 0; i < 8; i++) begin
      k = lsb ? i : 7 - i;
      sdio_en_o = !rd;
      sdio_o = tx[k];
      #HALF sclk_o = 1'b1;
      rx[k] = sdio_i;
      #HALF sclk_o = 1'b0;
    end
  endtask : shift
endmodule : scp_host_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the serial configuration port
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic        ref_clk_i, rst_n_i, sclk, cs_n, h_d, h_en;
  logic        sdio_w, d_o, d_oe_n, wr, off, lsb, ce;
  logic [12:0] w_addr, a;
  logic [7:0]  w_data;
  logic [31:0] seed;
  int          error_cnt, check_count;
  logic [7:0]  mem [256];
  logic [7:0]  dq [8];
  logic [7:0]  rq [8];
  logic [20:0] wq [$];
  logic [20:0] eq [$];

  // Line has a pull-down when nobody drives it
  assign sdio_w = (d_oe_n === 1'b0) ? d_o : (h_en ? h_d : 1'b0);

  scp_config_port scp_config_port_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .sclk_i(sclk), .chip_select_n_i(cs_n), .sdio_i(sdio_w),
    .sdio_o(d_o), .sdio_oe_n_o(d_oe_n), .cfg_wr_o(wr),
    .cfg_addr_o(w_addr), .cfg_data_o(w_data), .serial_off_o(off));

  scp_host_model scp_host_model_inst (
    .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(h_d), .sdio_en_o(h_en),
    .sdio_i(sdio_w));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) if (wr === 1'b1) wq.push_back({w_addr, w_data});

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Expected writes and model memory follow the bytes as sent
  task automatic xfer(input logic rd, input logic [1:0] len, input int n,
                      input logic pause, input logic keep);
    logic [15:0] ins;
    logic [7:0]  rx;
    ins = {rd, len, a};
    if (cs_n) scp_host_model_inst.select(1'b0);
    scp_host_model_inst.shift(ins[15:8], 1'b0, lsb, rx);
    scp_host_model_inst.shift(ins[7:0], 1'b0, lsb, rx);
    for (int i = 0; i < n; i++) begin
      if (pause) scp_host_model_inst.select(1'b1);
      if (pause) scp_host_model_inst.select(1'b0);
      scp_host_model_inst.shift(dq[i], rd, lsb, rq[i]);
      if (!rd) begin
        mem[8'(a[7:0] + i)] = dq[i];
        eq.push_back({13'(a + i), dq[i]});
        if (8'(a[7:0] + i) == 8'h00) lsb = dq[i][6];
      end
    end
    if (!keep) scp_host_model_inst.select(1'b1);
  endtask : xfer

  task automatic rnd(input int n);
    seed = lfsr(seed);
    a = {seed[28:24], 2'b01, seed[13:8]};
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      dq[i] = seed[7:0];
    end
  endtask : rnd

  task automatic drain();
    repeat (12) @(posedge ref_clk_i);
    chk(wq.size(), eq.size(), "write count");
    while (wq.size() > 0 && eq.size() > 0) chk(wq.pop_front(),
      eq.pop_front(), "write addr or data");
    wq.delete();
    eq.delete();
  endtask : drain

  task automatic rdchk(input int n);
    for (int i = 0; i < n; i++) chk(rq[i], mem[8'(a[7:0] + i)], "read");
  endtask : rdchk

  initial begin
    rst_n_i = 1'b0;
    ce = 1'b1;
    error_cnt = 0;
    check_count = 0;
    seed = 32'h555D9040;
    lsb = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Link side needs two edges before it takes bits
    scp_host_model_inst.pulses(2);
    repeat (4) @(posedge ref_clk_i);
    chk(off, 1'b1, "port not off");
    for (int t = 0; t < 4; t++) begin
      rnd(1);
      xfer(1'b0, 2'h0, 1, 1'b0, t < 3);
    end
    drain();
    $display("single writes done");
    rnd(3);
    xfer(1'b0, 2'h2, 3, 1'b1, 1'b0);
    drain();
    $display("paused write done");
    rnd(5);
    xfer(1'b0, scp_pkg::LEN_STREAM, 5, 1'b0, 1'b0);
    drain();
    xfer(1'b1, 2'h2, 3, 1'b0, 1'b0);
    rdchk(3);
    xfer(1'b1, scp_pkg::LEN_STREAM, 5, 1'b0, 1'b0);
    rdchk(5);
    chk(d_oe_n, 1'b1, "line still driven");
    $display("reads done");
    scp_host_model_inst.select(1'b0);
    repeat (4) @(posedge ref_clk_i);
    chk(off, 1'b0, "port off while selected");
    scp_host_model_inst.pulses(4);
    scp_host_model_inst.select(1'b1);
    scp_host_model_inst.pulses(8);
    rnd(1);
    xfer(1'b0, 2'h0, 1, 1'b0, 1'b0);
    drain();
    $display("abort done");
    // A whole frame with the enable low must leave no trace
    @(posedge ref_clk_i) ce <= 1'b0;
    scp_host_model_inst.pulses(2);
    scp_host_model_inst.select(1'b0);
    repeat (4) @(posedge ref_clk_i);
    chk(off, 1'b1, "status moved while frozen");
    scp_host_model_inst.pulses(24);
    scp_host_model_inst.select(1'b1);
    @(posedge ref_clk_i) ce <= 1'b1;
    scp_host_model_inst.pulses(2);
    drain();
    $display("clock enable done");
    a = 13'h0000;
    dq[0] = 8'h40;
    xfer(1'b0, 2'h0, 1, 1'b0, 1'b0);
    rnd(2);
    xfer(1'b0, 2'h1, 2, 1'b0, 1'b0);
    xfer(1'b1, 2'h1, 2, 1'b0, 1'b0);
    rdchk(2);
    seed = {seed[31:13], a};
    a = 13'h0000;
    dq[0] = 8'h00;
    xfer(1'b0, 2'h0, 1, 1'b0, 1'b0);
    a = seed[12:0];
    xfer(1'b1, 2'h1, 2, 1'b0, 1'b0);
    rdchk(2);
    drain();
    $display("bit order done");
    stop_test();
  end

  // Whole run takes well under 100 us
  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
